//--- hw/pab_defines.svh
// Offsets, field positions, reset values and timing counts of the polled converter card
`ifndef PAB_DEFINES_SVH
`define PAB_DEFINES_SVH

`define PAB_WINDOW_SIZE      8
`define PAB_OFF_CHAN_PICK    3'h3
`define PAB_OFF_RESULT_LOW   3'h4
`define PAB_OFF_RESULT_HIGH  3'h5
`define PAB_FACTORY_BASE     16'hFF08
`define PAB_FACTORY_IN_IO    1'b0
`define PAB_CHAN_MSB         4
`define PAB_BUSY_BIT         7
`define PAB_MSBS_TOP         3
`define PAB_CHAN_RESET       5'h00
`define PAB_RESULT_RESET     12'h000
`define PAB_CLOCK_HZ         20000000
`define PAB_SETTLE_NS        15000
`define PAB_CYCLE_NS         40000
`define PAB_SETTLE_CYCLES    ((`PAB_SETTLE_NS * (`PAB_CLOCK_HZ / 1000000) + 999) / 1000)
`define PAB_CYCLE_CYCLES     ((`PAB_CYCLE_NS * (`PAB_CLOCK_HZ / 1000000)) / 1000)
`define PAB_CONVERT_CYCLES   (`PAB_CYCLE_CYCLES - `PAB_SETTLE_CYCLES - 4)
`define PAB_COUNT_W          10

`endif

//--- hw/pab_pkg.sv
// Types shared by the polled converter card logic
package pab_pkg;

  typedef enum logic [1:0] {
    PAB_FMT_BINARY = 2'h0,
    PAB_FMT_OFFSET = 2'h1,
    PAB_FMT_TWOS   = 2'h3
  } pab_format_t;

  typedef enum logic [1:0] {
    PAB_ST_IDLE    = 2'h0,
    PAB_ST_SETTLE  = 2'h1,
    PAB_ST_CONVERT = 2'h3,
    PAB_ST_LATCH   = 2'h2
  } pab_state_t;

endpackage

//--- hw/pab_conv_if.sv
// Link between the sequencer and the result formatter
interface pab_conv_if;
  import pab_pkg::*;
  logic [11:0] raw_code;
  logic        latch;
  logic [11:0] result;
  logic        busy;
  modport seq (output latch, output busy, input raw_code, input result);
  modport fmt (input latch, input raw_code, output result);
endinterface

//--- hw/pab_formatter.sv
// Result coding and holding register
`include "pab_defines.svh"
module pab_formatter
  import pab_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst,
  input  pab_format_t data_format,
  pab_conv_if.fmt     conv
);

  logic [11:0] result_reg;
  logic [11:0] result_next;

  // Converter delivers offset-binary code; top bit flips for two's complement
  always_comb begin
    result_next = result_reg;
    if (conv.latch) begin
      if (data_format == PAB_FMT_TWOS)
        result_next = {~conv.raw_code[11], conv.raw_code[10:0]}; // R14 R15
      else
        result_next = conv.raw_code; // R12 R13
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      result_reg <= `PAB_RESULT_RESET;
    else
      result_reg <= result_next;
  end

  assign conv.result = result_reg;

  chk_twos_sign_flip: assert property (@(posedge clock) disable iff (rst) // R15
    conv.latch && data_format == PAB_FMT_TWOS |=> result_reg[11] == ~$past(conv.raw_code[11]))
    else $error("two's complement top bit not inverted");
  chk_plain_copy: assert property (@(posedge clock) disable iff (rst) // R13
    conv.latch && data_format != PAB_FMT_TWOS |=> result_reg == $past(conv.raw_code))
    else $error("binary result not copied");
  chk_result_hold: assert property (@(posedge clock) disable iff (rst) // R21
    !conv.latch |=> $stable(result_reg))
    else $error("result changed without conversion");

endmodule // pab_formatter

//--- hw/pab_sequencer.sv
// Settle and conversion timing with busy flag
`include "pab_defines.svh"
module pab_sequencer
  import pab_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic conv_done,
  output logic      convert_start,
  pab_conv_if.seq   conv
);

  pab_state_t                 state_reg;
  pab_state_t                 state_next;
  logic [`PAB_COUNT_W-1:0]    count_reg;
  logic [`PAB_COUNT_W-1:0]    count_next;
  // Cycles since the last pick write; feeds the settle check only
  logic [`PAB_COUNT_W-1:0]    gap_reg;
  logic [`PAB_COUNT_W-1:0]    gap_next;

  always_comb begin
    gap_next = gap_reg;
    if (start)
      gap_next = `PAB_COUNT_W'(1);
    else if (gap_reg != '0 && gap_reg != '1)
      gap_next = gap_reg + 1'b1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      gap_reg <= '0;
    else
      gap_reg <= gap_next;
  end

  always_comb begin
    state_next    = state_reg;
    count_next    = count_reg;
    convert_start = 1'b0;
    conv.latch    = 1'b0;
    if (start) begin
      // A write mid-cycle restarts; the host should not do it
      state_next = PAB_ST_SETTLE; // R4
      count_next = `PAB_COUNT_W'(`PAB_SETTLE_CYCLES - 1); // R18
    end else begin
      case (state_reg)
        PAB_ST_IDLE: ;
        PAB_ST_SETTLE: begin
          if (count_reg == '0) begin
            state_next    = PAB_ST_CONVERT;
            convert_start = 1'b1;
            count_next    = `PAB_COUNT_W'(`PAB_CONVERT_CYCLES - 1);
          end else
            count_next = count_reg - 1'b1;
        end
        PAB_ST_CONVERT: begin
          // Finish on converter done or at the bound, whichever first
          if (conv_done || count_reg == '0)
            state_next = PAB_ST_LATCH; // R19
          else
            count_next = count_reg - 1'b1;
        end
        PAB_ST_LATCH: begin
          conv.latch = 1'b1;
          state_next = PAB_ST_IDLE; // R10
        end
        default: state_next = PAB_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= PAB_ST_IDLE;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign conv.busy = (state_reg != PAB_ST_IDLE);

  chk_settle_len: assert property (@(posedge clock) disable iff (rst) // R18
    convert_start |-> gap_reg == `PAB_COUNT_W'(`PAB_SETTLE_CYCLES))
    else $error("settle delay length wrong");

endmodule // pab_sequencer

//--- hw/pab_card.sv
// Bus-side register window of the polled 12-bit converter card
// ---------------------------------------------------------------
// Notes on behaviour
// R1: Eight-address window, three live registers
// R2: Strapped base, I/O or memory space
// R3: Channel pick at offset 3, write only
// R4: Each channel write starts a conversion
// R5: Host never writes pick while busy
// R6: Five-bit binary channel number, 0 to 31
// R7: Upper pick bits ignored
// R8: Offset 4 returns result bits 7:0
// R9: Offset 5 returns busy and bits 11:8
// R10: Busy high during conversion, clears when done
// R11: Host reads high byte before low
// R12: Binary code, upper high bits zero
// R13: Offset binary, 800 is zero volts
// R14: Two's complement, 000 is zero volts
// R15: Top bit inverted for two's complement
// R16: Sign copied into unused high bits
// R17: One static format for all channels
// R18: Settle 15 us before converting
// R19: Whole cycle within about 40 us
// R20: Channel bits 4:0, msbs in 3:0
// R21: Busy set on write, reads side-effect free
// ---------------------------------------------------------------
`include "pab_defines.svh"
module pab_card
  import pab_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr_n,
  input  wire logic        bus_rd_n,
  input  wire logic        bus_iorq_n,
  input  wire logic        bus_memrq_n,
  input  wire logic [15:0] strap_base,
  input  wire logic        strap_io_space,
  input  wire logic [1:0]  strap_format,
  input  wire logic [11:0] adc_code,
  input  wire logic        adc_done,
  output logic [7:0]       bus_rdata,
  output logic             bus_rdata_oe,
  output logic [4:0]       chan_code,
  output logic             adc_convert,
  output logic             busy
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [15:0] addr_s1_reg, addr_s2_reg;
  logic [7:0]  wdata_s1_reg, wdata_s2_reg;
  logic [3:0]  ctl_s1_reg, ctl_s2_reg;
  logic [11:0] code_s1_reg, code_s2_reg;
  logic        done_s1_reg, done_s2_reg;
  logic        wr_prev_reg;
  logic [15:0] base_reg;
  logic        io_reg;
  pab_format_t fmt_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_s1_reg  <= 16'h0000;
      addr_s2_reg  <= 16'h0000;
      wdata_s1_reg <= 8'h00;
      wdata_s2_reg <= 8'h00;
      ctl_s1_reg   <= 4'hF;
      ctl_s2_reg   <= 4'hF;
      code_s1_reg  <= 12'h000;
      code_s2_reg  <= 12'h000;
      done_s1_reg  <= 1'b0;
      done_s2_reg  <= 1'b0;
      wr_prev_reg  <= 1'b1;
    end else begin
      addr_s1_reg  <= bus_addr;
      addr_s2_reg  <= addr_s1_reg;
      wdata_s1_reg <= bus_wdata;
      wdata_s2_reg <= wdata_s1_reg;
      ctl_s1_reg   <= {bus_wr_n, bus_rd_n, bus_iorq_n, bus_memrq_n};
      ctl_s2_reg   <= ctl_s1_reg;
      code_s1_reg  <= adc_code;
      code_s2_reg  <= code_s1_reg;
      done_s1_reg  <= adc_done;
      done_s2_reg  <= done_s1_reg;
      wr_prev_reg  <= ctl_s2_reg[3];
    end
  end

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  // Straps are pins too, so they pass two flops before the capture
  logic [15:0] sbase_s1_reg, sbase_s2_reg;
  logic        sio_s1_reg, sio_s2_reg;
  logic [1:0]  sfmt_s1_reg, sfmt_s2_reg;
  logic        sok_s1_reg, sok_s2_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sbase_s1_reg <= 16'h0000;
      sbase_s2_reg <= 16'h0000;
      sio_s1_reg   <= 1'b0;
      sio_s2_reg   <= 1'b0;
      sfmt_s1_reg  <= 2'h0;
      sfmt_s2_reg  <= 2'h0;
      sok_s1_reg   <= 1'b0;
      sok_s2_reg   <= 1'b0;
    end else begin
      sbase_s1_reg <= strap_base;
      sbase_s2_reg <= sbase_s1_reg;
      sio_s1_reg   <= strap_io_space;
      sio_s2_reg   <= sio_s1_reg;
      sfmt_s1_reg  <= strap_format;
      sfmt_s2_reg  <= sfmt_s1_reg;
      sok_s1_reg   <= 1'b1;
      sok_s2_reg   <= sok_s1_reg;
    end
  end

  // Straps are caught once, third edge after reset release
  // Changing a strap later has no effect until the next reset
  logic straps_taken_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      straps_taken_reg <= 1'b0;
      base_reg         <= `PAB_FACTORY_BASE;
      io_reg           <= `PAB_FACTORY_IN_IO;
      fmt_reg          <= PAB_FMT_BINARY;
    end else if (sok_s2_reg && !straps_taken_reg) begin
      straps_taken_reg <= 1'b1;
      base_reg         <= {sbase_s2_reg[15:3], 3'h0}; // R2
      io_reg           <= sio_s2_reg; // R2
      fmt_reg          <= pab_format_t'(sfmt_s2_reg); // R17
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hits(input logic [15:0] a, input logic [15:0] b,
                                input logic io, input logic [3:0] ctl);
    hits = (a[15:3] == b[15:3]) && (io ? !ctl[1] : !ctl[0]); // R1
  endfunction

  logic       sel;
  logic [2:0] off;
  logic       wr_edge;
  assign sel     = straps_taken_reg && hits(addr_s2_reg, base_reg, io_reg, ctl_s2_reg);
  assign off     = addr_s2_reg[2:0];
  assign wr_edge = wr_prev_reg && !ctl_s2_reg[3];

  logic start;
  assign start = sel && wr_edge && off == `PAB_OFF_CHAN_PICK; // R3 R4

  // ---------------------------------------------------------------
  // Sequencer and formatter
  // ---------------------------------------------------------------
  pab_conv_if conv ();
  logic convert_start;
  assign conv.raw_code = code_s2_reg;

  pab_sequencer u_seq (
    .clock         (clock),
    .rst           (rst),
    .start         (start),
    .conv_done     (done_s2_reg),
    .convert_start (convert_start),
    .conv          (conv)
  );

  pab_formatter u_fmt (
    .clock       (clock),
    .rst         (rst),
    .data_format (fmt_reg),
    .conv        (conv)
  );

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [4:0] chan_reg, chan_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       oe_reg, oe_next;
  logic       conv_reg, busy_reg, busy_next;

  function automatic logic [7:0] high_byte(input logic b, input pab_format_t f,
                                           input logic [11:0] r);
    logic [2:0] ext;
    ext = (f == PAB_FMT_TWOS) ? {3{r[11]}} : 3'h0; // R12 R16
    high_byte = {b, ext, r[11:8]}; // R9 R20
  endfunction

  always_comb begin
    chan_next  = chan_reg;
    rdata_next = 8'h00;
    oe_next    = 1'b0;
    busy_next  = conv.busy;
    if (start) begin
      chan_next = wdata_s2_reg[`PAB_CHAN_MSB:0]; // R6 R7 R20
      busy_next = 1'b1; // R21
    end
    // Reads only steer the data pins, never touch state
    if (sel && !ctl_s2_reg[2]) begin
      case (off)
        `PAB_OFF_RESULT_LOW: begin
          rdata_next = conv.result[7:0]; // R8
          oe_next    = 1'b1;
        end
        `PAB_OFF_RESULT_HIGH: begin
          rdata_next = high_byte(busy_next, fmt_reg, conv.result); // R9 R10
          oe_next    = 1'b1;
        end
        default: oe_next = 1'b0; // R1
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chan_reg  <= `PAB_CHAN_RESET;
      rdata_reg <= 8'h00;
      oe_reg    <= 1'b0;
      conv_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      chan_reg  <= chan_next;
      rdata_reg <= rdata_next;
      oe_reg    <= oe_next;
      conv_reg  <= convert_start;
      busy_reg  <= busy_next;
    end
  end

  assign chan_code    = chan_reg;
  assign bus_rdata    = rdata_reg;
  assign bus_rdata_oe = oe_reg;
  assign adc_convert  = conv_reg;
  assign busy         = busy_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_pick_write;
    start;
  endsequence
  sequence s_busy_run;
    busy_reg [*8];
  endsequence

  chk_write_sets_busy: assert property (@(posedge clock) disable iff (rst) // R21
    s_pick_write |=> s_busy_run)
    else $error("busy not raised by channel write");
  chk_busy_bound: assert property (@(posedge clock) disable iff (rst) // R19
    s_pick_write ##1 (!start) [*8] |-> ##[0:800] !busy_reg)
    else $error("conversion too long");
  chk_chan_load: assert property (@(posedge clock) disable iff (rst) // R6
    start |=> chan_code == $past(wdata_s2_reg[4:0]))
    else $error("channel not latched");
  chk_dead_offsets: assert property (@(posedge clock) disable iff (rst) // R1
    sel && off != `PAB_OFF_RESULT_LOW && off != `PAB_OFF_RESULT_HIGH |=> !bus_rdata_oe)
    else $error("unused offset answered");
  chk_low_byte: assert property (@(posedge clock) disable iff (rst) // R8
    sel && !ctl_s2_reg[2] && off == `PAB_OFF_RESULT_LOW |=> bus_rdata == $past(conv.result[7:0]))
    else $error("low byte wrong");
  chk_high_busy: assert property (@(posedge clock) disable iff (rst) // R9
    sel && !ctl_s2_reg[2] && off == `PAB_OFF_RESULT_HIGH |=> bus_rdata[7] == busy_reg)
    else $error("busy bit wrong");
  chk_binary_zero: assert property (@(posedge clock) disable iff (rst) // R12
    fmt_reg != PAB_FMT_TWOS && bus_rdata_oe && $past(off) == `PAB_OFF_RESULT_HIGH
    |-> bus_rdata[6:4] == 3'h0)
    else $error("upper bits not zero");
  chk_sign_fill: assert property (@(posedge clock) disable iff (rst) // R16
    fmt_reg == PAB_FMT_TWOS && bus_rdata_oe && $past(off) == `PAB_OFF_RESULT_HIGH
    |-> bus_rdata[6:4] == {3{bus_rdata[3]}})
    else $error("sign not extended");

  // Side-effect, convert-pulse, static-configuration and read-drive guards
  chk_dead_write: assert property (@(posedge clock) disable iff (rst) // R1
    sel && wr_edge && off != `PAB_OFF_CHAN_PICK |=> $stable(chan_code))
    else $error("unused offset took a write");
  chk_read_quiet: assert property (@(posedge clock) disable iff (rst) // R21
    sel && !ctl_s2_reg[2] && !start |=> $stable(chan_code))
    else $error("read disturbed channel");
  chk_convert_pulse: assert property (@(posedge clock) disable iff (rst) // R18
    adc_convert |=> !adc_convert)
    else $error("convert pulse too long");
  chk_format_fixed: assert property (@(posedge clock) disable iff (rst) // R17
    straps_taken_reg |=> $stable(fmt_reg))
    else $error("format changed after capture");
  chk_base_fixed: assert property (@(posedge clock) disable iff (rst) // R2
    straps_taken_reg |=> $stable(base_reg) && $stable(io_reg))
    else $error("window moved after capture");
  chk_oe_from_read: assert property (@(posedge clock) disable iff (rst) // R1
    bus_rdata_oe |-> $past(sel && !ctl_s2_reg[2]))
    else $error("data driven without read");

endmodule // pab_card

//--- testbench/pab_adc_model.sv
// Converter stand-in that answers start pulses after a set delay
module pab_adc_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        adc_convert,
  input  wire logic [11:0] code_in,
  input  wire logic [9:0]  delay,
  output logic [11:0]      adc_code,
  output logic             adc_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  int hold;
  // ------
  // Answer
  // ------
  // Code is only meaningful around the done pulse; elsewhere it keeps toggling
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      hold <= 0;
      adc_code <= 12'hA5C;
      adc_done <= 1'b0;
    end else begin
      if (adc_convert) begin
        cnt <= int'(delay) + 1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
        adc_code <= ~adc_code;
      end else if (cnt == 1) begin
        cnt <= 0;
        hold <= 8;
        adc_code <= code_in;
      end else if (hold > 0) begin
        hold <= hold - 1;
      end else begin
        adc_code <= ~adc_code;
      end
      adc_done <= (cnt == 1) || (hold == 8);
    end
  end
endmodule // pab_adc_model

//--- testbench/testbench.sv
// Self-checking bench for the polled converter card bus window
module testbench;
  import pab_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic chk; logic [7:0] v;} pab_note_t;
  logic clock = 1'b0, rst = 1'b1, bus_wr_n = 1'b1, bus_rd_n = 1'b1;
  logic bus_iorq_n = 1'b1, bus_memrq_n = 1'b1, strap_io_space = 1'b0, oe_d = 1'b0;
  logic [15:0] bus_addr = 16'h0000, strap_base = 16'hFF08;
  logic [7:0] bus_wdata = 8'h00, bus_rdata;
  logic [1:0] strap_format = 2'h0;
  logic [11:0] adc_code, code_in = 12'h000;
  logic [9:0] delay = 10'h014;
  logic [4:0] chan_code;
  logic bus_rdata_oe, adc_convert, adc_done, busy;
  logic [31:0] seed = 32'h00017551;
  pab_note_t notes[$];
  pab_note_t n;
  int miscompares = 0, total_checks = 0, since_busy = 0;

  always #25 clock = ~clock;

  pab_card pab_card_i (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr_n(bus_wr_n), .bus_rd_n(bus_rd_n), .bus_iorq_n(bus_iorq_n),
    .bus_memrq_n(bus_memrq_n), .strap_base(strap_base), .strap_io_space(strap_io_space),
    .strap_format(strap_format), .adc_code(adc_code), .adc_done(adc_done),
    .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe), .chan_code(chan_code),
    .adc_convert(adc_convert), .busy(busy));
  pab_adc_model pab_adc_model_i (.clock(clock), .rst(rst), .adc_convert(adc_convert),
    .code_in(code_in), .delay(delay), .adc_code(adc_code), .adc_done(adc_done));

  // -------------
  // Helpers
  // -------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Strobe held 9 cycles: longer than the read answer delay
  task automatic access(logic wr, logic io, logic [15:0] a, logic [7:0] d,
                        output logic [7:0] q, output logic got);
    got = 1'b0;
    q = 8'h00;
    @(negedge clock);
    bus_addr = a;
    bus_wdata = d;
    bus_iorq_n = !io;
    bus_memrq_n = io;
    @(negedge clock);
    if (wr) bus_wr_n = 1'b0;
    else bus_rd_n = 1'b0;
    repeat (8) begin
      @(negedge clock);
      if (!wr && !got && bus_rdata_oe === 1'b1) begin
        q = bus_rdata;
        got = 1'b1;
      end
    end
    @(negedge clock);
    bus_wr_n = 1'b1;
    bus_rd_n = 1'b1;
    @(negedge clock);
    bus_iorq_n = 1'b1;
    bus_memrq_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask

  task automatic rd_reg(logic [2:0] off, logic chk, logic [7:0] exp, output logic [7:0] q);
    logic got;
    notes.push_back({chk, exp});
    access(1'b0, strap_io_space, strap_base + 16'(off), 8'h00, q, got);
    if (!got) begin
      miscompares++;
      $display("BAD read answer expected 1 seen 0");
      results();
    end
  endtask

  task automatic do_reset(pab_format_t f, logic io, logic [15:0] b);
    @(negedge clock);
    rst = 1'b1;
    strap_format = f;
    strap_io_space = io;
    strap_base = b;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  task automatic run(logic [11:0] raw);
    logic [7:0] q, d;
    logic [11:0] t;
    logic got;
    int i;
    d = 8'(rnd());
    code_in = raw;
    delay = 10'(rnd() % 80 + 5);
    access(1'b1, strap_io_space, strap_base + 16'h0003, d, q, got);
    check("chan", {7'h0, chan_code}, {7'h0, d[4:0]});
    check("busy set", {11'h0, busy}, 12'h001);
    q = 8'h80;
    for (i = 0; i < 100 && q[7] !== 1'b0; i++) rd_reg(3'h5, 1'b0, 8'h00, q);
    if (q[7] !== 1'b0) begin
      check("poll busy", {11'h0, q[7]}, 12'h000);
      results();
    end
    t = (strap_format == PAB_FMT_TWOS) ? {~raw[11], raw[10:0]} : raw;
    rd_reg(3'h5, 1'b1, {1'b0, (strap_format == PAB_FMT_TWOS) ? {3{t[11]}} : 3'h0,
      t[11:8]}, q);
    rd_reg(3'h4, 1'b1, t[7:0], q);
    $display("test code %h format %0d done", raw, strap_format);
  endtask

  // -------------
  // Watchers
  // -------------
  always @(posedge clock) begin
    if (bus_rdata_oe === 1'b1 && oe_d !== 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      if (n.chk) check("read", {4'h0, bus_rdata}, {4'h0, n.v});
    end
    oe_d <= bus_rdata_oe;
    if (adc_convert === 1'b1) check("settle", 12'(since_busy >= 295), 12'h001);
    if (busy !== 1'b1 && since_busy != 0) check("cycle", 12'(since_busy <= 800), 12'h001);
    since_busy <= (busy === 1'b1) ? since_busy + 1 : 0;
  end

  // -------------
  // Sequence
  // -------------
  initial begin
    pab_format_t fmts[3] = '{PAB_FMT_BINARY, PAB_FMT_OFFSET, PAB_FMT_TWOS};
    logic [11:0] codes[4] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF};
    logic [7:0] q;
    logic got;
    for (int f = 0; f < 3; f++) begin
      do_reset(fmts[f], f == 1, (f == 0) ? 16'hFF08 : 16'(rnd() & 32'h0000FFF8));
      check("idle busy", {11'h0, busy}, 12'h000);
      foreach (codes[k]) run(codes[k]);
      run(12'(rnd()));
    end
    for (int k = 0; k < 8; k++) begin
      if (k != 3) begin
        access(1'b1, strap_io_space, strap_base + 16'(k), 8'hFF, q, got);
        check("dead write", {11'h0, busy}, 12'h000);
      end
      if (k < 4 || k > 5) begin
        access(1'b0, strap_io_space, strap_base + 16'(k), 8'h00, q, got);
        check("dead read", {11'h0, got}, 12'h000);
      end
    end
    access(1'b0, !strap_io_space, strap_base + 16'h0005, 8'h00, q, got);
    check("other space", {11'h0, got}, 12'h000);
    $display("test refusals done");
    results();
  end
endmodule // testbench
